//--- bench/rx_back_end_and_channel_clocking_test.sv
// Purpose: self-checking bench of the receiver back end
// Assumes: fabric sink model takes the output stream
// Notes: inputs move on the falling edge, except swap, first set just after a rising edge; outputs judged when settled
`timescale 1ns/1ps
`default_nettype none
`include "rxbe_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module rx_back_end_and_channel_clocking_test import rxbe_pkg::*;;
  logic mclk, rst, low_latency, in_valid, out_valid, out_ready, in_ready;
  logic fabric_rd_clk_present, fabric_tx_wr_clk_present, half_clk;
  logic rate_matcher_used, front_end_on_recovered, tx_clk_out_halved;
  logic tx_fifo_wr_from_ch0, pipe_on_tx_clk_out, channel_independent;
  logic stall, aligned, swap; // fabric model controls
  rxbe_mode_t mode;
  logic [9:0] in_code; // bit 9 first on the line
  logic [15:0] out_data;
  logic [1:0] out_ctrl, out_err, out_disperr;
  rxbe_dclk_t deser_clk_sel;
  rxbe_wclk_t fifo_wr_clk_sel;
  rxbe_rclk_t fifo_rd_clk_sel;
  logic [20:0] serial_khz, par_khz, fabric_khz;
  int errors = 0;
  int compares = 0;

  rxbe_rx_back_end i_rxbe_rx_back_end (.mclk, .rst, .mode, .low_latency,
    .fabric_rd_clk_present, .fabric_tx_wr_clk_present, .in_valid,
    .in_ready, .in_code, .out_valid, .out_ready, .out_data, .out_ctrl,
    .out_err, .out_disperr, .deser_clk_sel, .fifo_wr_clk_sel,
    .fifo_rd_clk_sel, .rate_matcher_used, .front_end_on_recovered,
    .tx_clk_out_halved, .tx_fifo_wr_from_ch0, .pipe_on_tx_clk_out,
    .channel_independent, .half_clk, .serial_khz, .par_khz, .fabric_khz);

  rxbe_fabric_sink i_rxbe_fabric_sink (.mclk, .rst, .stall, .aligned,
    .swap, .out_valid, .out_ready, .out_data, .out_ctrl, .out_err,
    .out_disperr);

  // 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic fall(input int n);
    repeat (n) @(negedge mclk);
  endtask : fall

  // decoded byte of the few code groups used here
  function automatic logic [7:0] db(input logic [9:0] c);
    return (c == 10'h155) ? 8'h4a : (c == 10'h2aa) ? 8'hb5 : 8'hbc;
  endfunction : db

  // neutral groups only, so disparity never enters the fill test
  function automatic logic [9:0] cg(input int k);
    return (k % 3 == 0) ? 10'h155 : 10'h2aa;
  endfunction : cg

  // hold the group until a falling edge shows ready, then take edge
  task automatic send(input logic [9:0] c);
    int n;
    n = 0;
    fall(1);
    in_valid = 1'b1;
    in_code = c;
    while (in_ready !== 1'b1 && n < 500) begin
      fall(1);
      n++;
    end
    @(posedge mclk);
  endtask : send

  task automatic idle();
    fall(1);
    in_valid = 1'b0;
  endtask : idle

  // bounded wait for n taken words
  task automatic drain(input int n);
    for (int k = 0; k < 100 && i_rxbe_fabric_sink.got.size() < n; k++)
      fall(1);
    `CHK(i_rxbe_fabric_sink.got.size(), n)
  endtask : drain

  task automatic word(input logic [21:0] e);
    logic [21:0] g;
    g = 'x;
    if (i_rxbe_fabric_sink.got.size() > 0) begin
      g = i_rxbe_fabric_sink.got.pop_front();
    end
    `CHK(g, e)
  endtask : word

  task automatic set_cfg(input rxbe_mode_t m, input logic ll, rc, tc);
    fall(1);
    mode = m;
    low_latency = ll;
    fabric_rd_clk_present = rc;
    fabric_tx_wr_clk_present = tc;
    fall(2);
  endtask : set_cfg

  // e: {rate matcher, write clk, read clk, halved, pipe, ch0, indep}
  task automatic cfg_chk(input rxbe_mode_t m, input logic ll, rc, tc,
                         input logic [8:0] e, input logic [62:0] r);
    set_cfg(m, ll, rc, tc);
    `CHK({rate_matcher_used, fifo_wr_clk_sel, fifo_rd_clk_sel,
          tx_clk_out_halved, pipe_on_tx_clk_out, tx_fifo_wr_from_ch0,
          channel_independent}, e)
    `CHK({serial_khz, par_khz, fabric_khz}, r)
  endtask : cfg_chk

  task automatic t_reset();
    logic h;
    fall(16);
    `CHK({out_valid, in_ready, half_clk, rate_matcher_used}, 4'b0100)
    `CHK({front_end_on_recovered, channel_independent, serial_khz,
          deser_clk_sel, fifo_wr_clk_sel, fifo_rd_clk_sel},
         {2'b11, 21'h0, rxbe_dclk_recovered, rxbe_wclk_recov_half,
          rxbe_rclk_fabric})
    rst = 1'b0;
    fall(1);
    h = half_clk;
    fall(1);
    `CHK(half_clk, ~h)
    $display("test reset done");
  endtask : t_reset

  // first unbalanced group sets disparity, whichever column it is
  task automatic t_first();
    send(10'h2aa);
    send(10'h155);
    idle();
    fall(6);
    aligned = 1'b1;
    send(10'h305);
    send(10'h0fa);
    swap = 1'b1;
    send(10'h155);
    send(10'h2aa);
    idle();
    drain(2);
    word({6'b000011, 8'hbc, 8'hbc});
    word({6'b000000, 8'h4a, 8'hb5});
    swap = 1'b0;
    $display("test first disparity done");
  endtask : t_first

  task automatic t_pairs();
    send(10'h305);
    send(10'h2aa);
    send(10'h155);
    send(10'h0fa);
    send(10'h0fa);
    send(10'h2aa);
    idle();
    drain(3);
    word({6'b000001, 8'hb5, 8'hbc});
    word({6'b000010, 8'hbc, 8'h4a});
    word({6'b010101, 8'hb5, 8'hbc});
    $display("test pairs done");
  endtask : t_pairs

  task automatic t_gigabit_ethernet_mode();
    set_cfg(rxbe_gigabit_ethernet_mode, 1'b0, 1'b0, 1'b0);
    send(10'h155);
    send(10'h2aa);
    idle();
    drain(2);
    word({6'b000000, 8'h00, 8'h4a});
    word({6'b000000, 8'h00, 8'hb5});
    $display("test bypass done");
  endtask : t_gigabit_ethernet_mode

  // stalled fabric: buffer fills, input refused, nothing lost
  task automatic t_full();
    set_cfg(rxbe_pcie_x1, 1'b0, 1'b0, 1'b0);
    fall(1);
    rst = 1'b1;
    fall(2);
    rst = 1'b0;
    stall = 1'b1;
    for (int k = 0; k < 10; k++) send(cg(k));
    // the refused group must stand unchanged while ready is low
    fall(4);
    `CHK(in_ready, 1'b0)
    stall = 1'b0;
    send(cg(10));
    send(cg(11));
    idle();
    drain(6);
    for (int k = 0; k < 6; k++) word({6'b0, db(cg(2*k+1)), db(cg(2*k))});
    $display("test full done");
  endtask : t_full

  task automatic t_cfg();
    cfg_chk(rxbe_pcie_x1, 1'b0, 1'b0, 1'b0, {1'b1, rxbe_wclk_local_half,
      rxbe_rclk_tx_par_out, 4'b1111}, {`RXBE_KHZ_1250, `RXBE_KHZ_250,
      `RXBE_KHZ_125});
    `CHK(deser_clk_sel, rxbe_dclk_cmu)
    cfg_chk(rxbe_gigabit_ethernet_mode, 1'b0, 1'b0, 1'b0, {1'b1, rxbe_wclk_local_par,
      rxbe_rclk_tx_par_out, 4'b0011}, {`RXBE_KHZ_625, `RXBE_KHZ_125,
      `RXBE_KHZ_125});
    cfg_chk(rxbe_srio_1g25, 1'b0, 1'b0, 1'b0, {1'b0, rxbe_wclk_recov_half,
      rxbe_rclk_rx_half_out, 4'b1011}, {`RXBE_KHZ_625, `RXBE_KHZ_125,
      `RXBE_KHZ_62P5});
    `CHK({deser_clk_sel, front_end_on_recovered},
         {rxbe_dclk_recovered, 1'b1})
    cfg_chk(rxbe_srio_2g5, 1'b0, 1'b1, 1'b1, {1'b0, rxbe_wclk_recov_half,
      rxbe_rclk_fabric, 4'b1001}, {`RXBE_KHZ_1250, `RXBE_KHZ_250,
      `RXBE_KHZ_125});
    cfg_chk(rxbe_pcie_x1, 1'b1, 1'b0, 1'b0, {1'b0, rxbe_wclk_recov_half,
      rxbe_rclk_rx_half_out, 4'b1111}, {`RXBE_KHZ_1250, `RXBE_KHZ_250,
      `RXBE_KHZ_125});
    set_cfg(rxbe_pcie_x4, 1'b0, 1'b0, 1'b0);
    `CHK({fifo_wr_clk_sel, fifo_rd_clk_sel, tx_fifo_wr_from_ch0,
          channel_independent},
         {rxbe_wclk_central_half, rxbe_rclk_bonded, 2'b00})
    $display("test clock selection done");
  endtask : t_cfg

  task automatic stop_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // main sequence; reset held for the first 16 cycles
  initial begin
    rst = 1'b1;
    mode = rxbe_pcie_x1;
    low_latency = 1'b0;
    fabric_rd_clk_present = 1'b0;
    fabric_tx_wr_clk_present = 1'b0;
    in_valid = 1'b0;
    in_code = 10'h000;
    stall = 1'b0;
    aligned = 1'b0;
    swap = 1'b0;
    t_reset();
    t_first();
    t_pairs();
    t_gigabit_ethernet_mode();
    t_full();
    t_cfg();
    stop_test();
  end

  // whole run is about a hundred cycles; cut a hang well beyond it
  initial begin
    #(100 * 20000);
    errors++;
    stop_test();
  end
endmodule : rx_back_end_and_channel_clocking_test
`default_nettype wire

//--- bench/rxbe_fabric_sink.sv
// Purpose: fabric side consumer of the received word stream
// Assumes: words offered on valid/ready, one clock
// Notes: taken words are queued for the bench to compare
`timescale 1ns/1ps
`default_nettype none
module rxbe_fabric_sink (
  input wire logic mclk,
  input wire logic rst,
  input wire logic stall,
  input wire logic aligned,
  input wire logic swap,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [15:0] out_data,
  input wire logic [1:0] out_ctrl,
  input wire logic [1:0] out_err,
  input wire logic [1:0] out_disperr
);
  // taken words: {disperr, err, ctrl, data} after byte repair
  logic [21:0] got [$];

  initial out_ready = 1'b0;

  // ready moves just after the edge; stall models a slow consumer
  always @(posedge mclk) begin
    out_ready <= !stall && !rst;
  end

  // words before alignment are dropped as meaningless
  always @(posedge mclk) begin
    if (!rst && out_valid && out_ready && aligned) begin
      if (swap) begin
        got.push_back({out_disperr[0], out_disperr[1], out_err[0],
                       out_err[1], out_ctrl[0], out_ctrl[1],
                       out_data[7:0], out_data[15:8]});
      end else begin
        got.push_back({out_disperr, out_err, out_ctrl, out_data});
      end
    end
  end
endmodule : rxbe_fabric_sink
`default_nettype wire

//--- core/rxbe_phase_fifo.sv
// Purpose: phase compensation buffer between decoder and fabric
// Assumes: one clock; valid/ready on both sides
// Notes: full and empty are exact, no write is taken while full
`timescale 1ns/1ps
`default_nettype none
module rxbe_phase_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];  // storage words
  logic [AW-1:0] wr_ptr;  // next slot to fill
  logic [AW-1:0] rd_ptr;  // oldest slot
  logic [AW:0] count;  // words held
  logic push;
  logic pop;

  assign wr_ready = (count != (AW+1)'(DEPTH));
  assign rd_valid = (count != '0);
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;
  assign rd_data = mem[rd_ptr];

  // storage write, no reset needed for data
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // occupancy
  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end
endmodule : rxbe_phase_fifo
`default_nettype wire

//--- core/rxbe_rx_back_end.sv
// Purpose: decoder, byte deserializer, phase buffer and clock selection
// Assumes: code groups arrive already word aligned on mclk
// Notes: clock routing is reported as source selects and rates
`timescale 1ns/1ps
`default_nettype none
`include "rxbe_defines.svh"
module rxbe_rx_back_end import rxbe_pkg::*; #(
  parameter int FIFO_DEPTH = `RXBE_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire rxbe_mode_t mode,
  input wire logic low_latency,
  input wire logic fabric_rd_clk_present,
  input wire logic fabric_tx_wr_clk_present,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [9:0] in_code,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data,
  output logic [1:0] out_ctrl,
  output logic [1:0] out_err,
  output logic [1:0] out_disperr,
  output rxbe_dclk_t deser_clk_sel,
  output rxbe_wclk_t fifo_wr_clk_sel,
  output rxbe_rclk_t fifo_rd_clk_sel,
  output logic rate_matcher_used,
  output logic front_end_on_recovered,
  output logic tx_clk_out_halved,
  output logic tx_fifo_wr_from_ch0,
  output logic pipe_on_tx_clk_out,
  output logic channel_independent,
  output logic half_clk,
  output logic [20:0] serial_khz,
  output logic [20:0] par_khz,
  output logic [20:0] fabric_khz
);

  // 6b sub-block to {valid, 5 bits}; positive forms are folded first
  function automatic logic [5:0] dec6(input logic [5:0] c);
    logic [5:0] n;
    logic [5:0] r;
    n = ($countones(c) == 2) ? ~c : c;
    if (c == `RXBE_D7_ALT_6B) n = `RXBE_D7_NORM_6B;
    case (n)
      6'h27: r = 6'h20;
      6'h1d: r = 6'h21;
      6'h2d: r = 6'h22;
      6'h31: r = 6'h23;
      6'h35: r = 6'h24;
      6'h29: r = 6'h25;
      6'h19: r = 6'h26;
      6'h38: r = 6'h27;
      6'h39: r = 6'h28;
      6'h25: r = 6'h29;
      6'h15: r = 6'h2a;
      6'h34: r = 6'h2b;
      6'h0d: r = 6'h2c;
      6'h2c: r = 6'h2d;
      6'h1c: r = 6'h2e;
      6'h17: r = 6'h2f;
      6'h1b: r = 6'h30;
      6'h23: r = 6'h31;
      6'h13: r = 6'h32;
      6'h32: r = 6'h33;
      6'h0b: r = 6'h34;
      6'h2a: r = 6'h35;
      6'h1a: r = 6'h36;
      6'h3a: r = 6'h37;
      6'h33: r = 6'h38;
      6'h26: r = 6'h39;
      6'h16: r = 6'h3a;
      6'h36: r = 6'h3b;
      6'h0e: r = 6'h3c;
      6'h2e: r = 6'h3d;
      6'h1e: r = 6'h3e;
      6'h2b: r = 6'h3f;
      6'h0f: r = 6'h3c;  // K28 comma form
      default: r = 6'h00;  // not a code
    endcase
    return r;
  endfunction : dec6

  // 4b sub-block to {valid, 3 bits}
  function automatic logic [3:0] dec4(input logic [3:0] c);
    logic [3:0] n;
    logic [3:0] r;
    n = ($countones(c) == 1) ? ~c : c;
    if (c == `RXBE_X3_ALT_4B) n = `RXBE_X3_NORM_4B;
    case (n)
      4'hb: r = 4'h8;
      4'h9: r = 4'h9;
      4'h5: r = 4'ha;
      4'hc: r = 4'hb;
      4'hd: r = 4'hc;
      4'ha: r = 4'hd;
      4'h6: r = 4'he;
      4'he: r = 4'hf;
      4'h7: r = 4'hf;  // alternate x.7
      default: r = 4'h0;
    endcase
    return r;
  endfunction : dec4

  // rate matcher presence per mode
  function automatic logic has_rm(input rxbe_mode_t m, input logic ll);
    case (m)
      rxbe_gigabit_ethernet_mode: has_rm = 1'b1;
      rxbe_srio_1g25: has_rm = 1'b0;
      rxbe_srio_2g5: has_rm = 1'b0;
      default: has_rm = !ll;
    endcase
  endfunction : has_rm

  logic [5:0] c6;  // decoded 6b sub-block
  logic [3:0] c4;  // decoded 4b sub-block
  logic code_ok;  // legal code group
  logic code_pos;  // more ones than zeros
  logic code_neg;  // more zeros than ones
  logic code_k;  // control group
  logic take;  // code group accepted
  logic rd_known;  // running disparity learned
  logic rd_pos;  // running disparity positive
  logic d_valid;  // decoded byte waiting
  logic [7:0] d_byte;
  logic d_ctrl;
  logic d_err;
  logic d_disperr;
  logic bypass;  // ethernet: single byte words
  logic hi_phase;  // next byte fills the upper lane
  logic [7:0] lo_byte;  // held lower byte
  logic lo_ctrl;
  logic lo_err;
  logic lo_disperr;
  logic consume;  // decoded byte leaves the stage
  logic wr_valid;
  logic wr_ready;
  logic [21:0] wr_data;
  logic [21:0] rd_data;
  logic rm_now;  // rate matcher in this mode
  logic deser_now;  // byte deserializer in this mode

  assign c6 = dec6(in_code[9:4]);
  // a K28 6b block in its positive form inverts the 4b block after it
  assign c4 = dec4((in_code[9:4] == ~`RXBE_K28_6B) ? ~in_code[3:0]
    : in_code[3:0]);
  assign code_pos = $countones(in_code) > 5;
  assign code_neg = $countones(in_code) < 5;
  // K28.y, or the alternate x.7 after 23, 27, 29, 30, 31
  assign code_k = (in_code[9:4] == `RXBE_K28_6B)
    || (in_code[9:4] == ~`RXBE_K28_6B)
    || ((in_code[3:0] == `RXBE_A7_4B || in_code[3:0] == ~`RXBE_A7_4B)
      && (c6[4:0] == 5'h17 || c6[4:0] == 5'h1b
        || c6[4:0] >= 5'h1d));
  assign code_ok = c6[5] && c4[3] && !(code_pos && $countones(in_code) > 6)
    && !(code_neg && $countones(in_code) < 4);
  assign rm_now = has_rm(mode, low_latency);
  assign deser_now = (mode != rxbe_gigabit_ethernet_mode);
  assign bypass = !deser_now;
  assign in_ready = !d_valid || consume;  // stall reaches the source
  assign take = in_valid && in_ready;

  // decoder output stage; cleared while reset is held
  always_ff @(posedge mclk) begin
    if (rst) begin
      d_valid <= 1'b0;
      d_byte <= `RXBE_BYTE_RESET;
      d_ctrl <= 1'b0;
      d_err <= 1'b0;
      d_disperr <= 1'b0;
    end else if (take) begin
      d_valid <= 1'b1;
      d_byte <= {c4[2:0], c6[4:0]};
      d_ctrl <= code_ok && code_k;
      // no disparity check until the first unbalanced valid group sets it
      d_disperr <= code_ok && rd_known
        && ((rd_pos && code_pos) || (!rd_pos && code_neg));
      d_err <= !code_ok || (rd_known
        && ((rd_pos && code_pos) || (!rd_pos && code_neg)));
    end else if (consume) begin
      d_valid <= 1'b0;
    end
  end

  // running disparity, learned from the first unbalanced valid group
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_known <= 1'b0;
      rd_pos <= `RXBE_RD_RESET;
    end else if (take && code_ok && (code_pos || code_neg)) begin
      rd_known <= 1'b1;
      rd_pos <= code_pos;
    end
  end

  // byte deserializer; the first byte goes low, so order may swap
  assign wr_valid = d_valid && (bypass || hi_phase);
  assign consume = d_valid && (!wr_valid || wr_ready);
  assign wr_data = bypass
    ? {8'h00, d_byte, 1'b0, d_ctrl, 1'b0, d_err, 1'b0, d_disperr}
    : {d_byte, lo_byte, d_ctrl, lo_ctrl, d_err, lo_err,
       d_disperr, lo_disperr};

  // lane phase and held lower byte
  always_ff @(posedge mclk) begin
    if (rst) begin
      hi_phase <= 1'b0;
      lo_byte <= `RXBE_BYTE_RESET;
      lo_ctrl <= 1'b0;
      lo_err <= 1'b0;
      lo_disperr <= 1'b0;
    end else if (bypass) begin
      hi_phase <= 1'b0;
    end else if (consume) begin
      hi_phase <= !hi_phase;
      if (!hi_phase) begin
        lo_byte <= d_byte;
        lo_ctrl <= d_ctrl;
        lo_err <= d_err;
        lo_disperr <= d_disperr;
      end
    end
  end

  // phase buffer; depth covers drift between write and read sides
  rxbe_phase_fifo #(
    .WIDTH(22),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .wr_valid(wr_valid),
    .wr_ready(wr_ready),
    .wr_data(wr_data),
    .rd_valid(out_valid),
    .rd_ready(out_ready),
    .rd_data(rd_data)
  );

  assign out_data = rd_data[21:6];
  assign out_ctrl = rd_data[5:4];
  assign out_err = rd_data[3:2];
  assign out_disperr = rd_data[1:0];

  // clock source selection, registered from the mode inputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      deser_clk_sel <= rxbe_dclk_recovered;
      fifo_wr_clk_sel <= rxbe_wclk_recov_half;
      fifo_rd_clk_sel <= rxbe_rclk_fabric;
      rate_matcher_used <= 1'b0;
      front_end_on_recovered <= 1'b1;
    end else begin
      rate_matcher_used <= rm_now;
      front_end_on_recovered <= !rm_now;
      deser_clk_sel <= rm_now ? rxbe_dclk_cmu
        : rxbe_dclk_recovered;
      if (mode == rxbe_pcie_x4) begin
        fifo_wr_clk_sel <= rxbe_wclk_central_half;
      end else if (rm_now) begin
        fifo_wr_clk_sel <= deser_now ? rxbe_wclk_local_half
          : rxbe_wclk_local_par;
      end else begin
        fifo_wr_clk_sel <= rxbe_wclk_recov_half;
      end
      if (fabric_rd_clk_present) begin
        fifo_rd_clk_sel <= rxbe_rclk_fabric;
      end else if (mode == rxbe_pcie_x4) begin
        fifo_rd_clk_sel <= rxbe_rclk_bonded;
      end else if (rm_now) begin
        fifo_rd_clk_sel <= rxbe_rclk_tx_par_out;
      end else begin
        fifo_rd_clk_sel <= rxbe_rclk_rx_half_out;
      end
    end
  end

  // transmit side clock routing flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_clk_out_halved <= 1'b0;
      tx_fifo_wr_from_ch0 <= 1'b0;
      pipe_on_tx_clk_out <= 1'b0;
      channel_independent <= 1'b1;
    end else begin
      tx_clk_out_halved <= deser_now;
      tx_fifo_wr_from_ch0 <= !fabric_tx_wr_clk_present
        && (mode != rxbe_pcie_x4);
      pipe_on_tx_clk_out <= (mode == rxbe_pcie_x1);
      channel_independent <= (mode != rxbe_pcie_x4);
    end
  end

  // divide-by-two of the parallel clock, as the exported half clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      half_clk <= 1'b0;
    end else begin
      half_clk <= !half_clk;
    end
  end

  // rates: serial is half the line rate, parallel is serial over five
  always_ff @(posedge mclk) begin
    if (rst) begin
      serial_khz <= '0;
      par_khz <= '0;
      fabric_khz <= '0;
    end else begin
      case (mode)
        rxbe_gigabit_ethernet_mode: begin
          serial_khz <= `RXBE_KHZ_625;
          par_khz <= `RXBE_KHZ_125;
          fabric_khz <= `RXBE_KHZ_125;
        end
        rxbe_srio_1g25: begin
          serial_khz <= `RXBE_KHZ_625;
          par_khz <= `RXBE_KHZ_125;
          fabric_khz <= `RXBE_KHZ_62P5;
        end
        default: begin
          serial_khz <= `RXBE_KHZ_1250;
          par_khz <= `RXBE_KHZ_250;
          fabric_khz <= `RXBE_KHZ_125;
        end
      endcase
    end
  end

  dec_reset_clear_a: assert property (@(posedge mclk)
    rst |=> !d_valid && !rd_known && d_byte == 8'h00 && !d_err)
    else $error("decoder not cleared by reset");

  rd_first_a: assert property (@(posedge mclk) disable iff (rst)
    !rd_known && take |=> !d_disperr)
    else $error("disparity error before disparity known");

  rd_learn_a: assert property (@(posedge mclk) disable iff (rst)
    !rd_known && take && code_ok && code_pos |=> rd_known && rd_pos)
    else $error("running disparity not learned");

  pair_word_a: assert property (@(posedge mclk) disable iff (rst)
    wr_valid && wr_ready && !bypass |=> !hi_phase && out_valid)
    else $error("deserializer pairing lost");

  bypass_lane_a: assert property (@(posedge mclk) disable iff (rst)
    wr_valid && bypass |-> wr_data[21:14] == 8'h00
      && wr_data[13:6] == d_byte)
    else $error("bypass word wrong");

  deser_clk_a: assert property (@(posedge mclk) disable iff (rst)
    rm_now |=> deser_clk_sel == rxbe_dclk_cmu)
    else $error("deserializer clock not multiplier");

  stall_hold_a: assert property (@(posedge mclk) disable iff (rst)
    d_valid && !consume |=> d_valid && $stable(d_byte))
    else $error("decoded byte lost under stall");

  no_rm_wr_a: assert property (@(posedge mclk) disable iff (rst)
    !rm_now && mode != rxbe_pcie_x4
      |=> fifo_wr_clk_sel == rxbe_wclk_recov_half)
    else $error("write clock not recovered half");

  rd_fabric_a: assert property (@(posedge mclk) disable iff (rst)
    fabric_rd_clk_present |=> fifo_rd_clk_sel == rxbe_rclk_fabric)
    else $error("read clock not fabric clock");

  bonded_wr_a: assert property (@(posedge mclk) disable iff (rst)
    mode == rxbe_pcie_x4 |=> fifo_wr_clk_sel == rxbe_wclk_central_half)
    else $error("bonded write clock wrong");

  tx_half_a: assert property (@(posedge mclk) disable iff (rst)
    mode == rxbe_gigabit_ethernet_mode ##1 mode == rxbe_gigabit_ethernet_mode |=> !tx_clk_out_halved)
    else $error("ethernet transmit clock halved");

  k_flag_a: assert property (@(posedge mclk) disable iff (rst)
    take && code_ok && in_code[9:4] == 6'h0f |=> d_ctrl)
    else $error("control group not flagged");

endmodule : rxbe_rx_back_end
`default_nettype wire

//--- inc/rxbe_defines.svh
// Purpose: shared constants of the receiver back end
// Assumes: included by bare name after the package
// Notes: code group bit 9 is the first bit on the line
`ifndef RXBE_DEFINES_SVH
`define RXBE_DEFINES_SVH

// code group forms, normalised to the negative disparity column
`define RXBE_K28_6B 6'h0f
`define RXBE_D7_ALT_6B 6'h07
`define RXBE_D7_NORM_6B 6'h38
`define RXBE_X3_ALT_4B 4'h3
`define RXBE_X3_NORM_4B 4'hc
`define RXBE_A7_4B 4'h7
`define RXBE_P7_4B 4'he

// reset values
`define RXBE_RD_RESET 1'b0
`define RXBE_BYTE_RESET 8'h00

// clock rates in kHz: serial / parallel / fabric
`define RXBE_KHZ_1250 21'h1312d0
`define RXBE_KHZ_625 21'h098968
`define RXBE_KHZ_250 21'h03d090
`define RXBE_KHZ_125 21'h01e848
`define RXBE_KHZ_62P5 21'h00f424

// phase compensation buffer depth
`define RXBE_FIFO_DEPTH 4

`endif

//--- inc/rxbe_pkg.sv
// Purpose: types of the receiver back end
// Assumes: nothing
// Notes: mode and clock source encodings
package rxbe_pkg;

  // functional mode of the channel
  typedef enum logic [2:0] {
    rxbe_pcie_x1,
    rxbe_gigabit_ethernet_mode,
    rxbe_srio_1g25,
    rxbe_srio_2g5,
    rxbe_pcie_x4
  } rxbe_mode_t;

  // byte deserializer write clock source
  typedef enum logic {
    rxbe_dclk_recovered,
    rxbe_dclk_cmu
  } rxbe_dclk_t;

  // phase compensation buffer write clock source
  typedef enum logic [1:0] {
    rxbe_wclk_local_par,
    rxbe_wclk_local_half,
    rxbe_wclk_recov_half,
    rxbe_wclk_central_half
  } rxbe_wclk_t;

  // phase compensation buffer read clock source
  typedef enum logic [1:0] {
    rxbe_rclk_fabric,
    rxbe_rclk_tx_par_out,
    rxbe_rclk_rx_half_out,
    rxbe_rclk_bonded
  } rxbe_rclk_t;

endpackage : rxbe_pkg
